// File: rtl/ihae_engine.v
// Intranet header check, relay, acknowledgement build and end-to-end timer
`timescale 1ns/1ps
`include "ihae_map.vh"
module ihae_engine #(
  parameter MAX_PATH = 4,
  parameter TICK_CYCLES = `IHAE_TICK_CYCLES,
  parameter FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Station configuration
  input wire [31:0] own_addr,
  input wire [9:0] fixed_sec,
  input wire [9:0] link_ack_sec,
  // Received header summary from the link layer, one beat
  input wire rx_valid,
  output wire rx_ready,
  input wire [3:0] rx_version,
  input wire [3:0] rx_msg_type,
  input wire [7:0] rx_header_octet_count,
  input wire [7:0] rx_msg_id,
  input wire [7:0] rx_hop_limit,
  input wire [31:0] rx_orig_addr,
  input wire [2:0] rx_path_len,
  input wire [32*MAX_PATH-1:0] rx_path_addr,
  input wire [8*MAX_PATH-1:0] rx_path_status,
  input wire [7:0] rx_payload,
  // Delivery to upper clients
  output reg deliver_valid,
  output reg [3:0] deliver_type,
  output reg [7:0] deliver_msg_id,
  output reg unsupported,
  output reg header_error,
  // Relay decision toward the link layer
  output reg fwd_valid,
  output reg [7:0] fwd_hop_limit,
  // Acknowledgement packet toward the link layer
  output wire ack_tx_valid,
  input wire ack_tx_ready,
  output reg [3:0] ack_version,
  output reg [3:0] ack_msg_type,
  output reg [7:0] ack_header_octet_count,
  output reg [7:0] ack_msg_id,
  output reg [31:0] ack_dest_addr,
  output reg [2:0] ack_path_len,
  output reg [32*MAX_PATH-1:0] ack_path_addr,
  output reg [8*MAX_PATH-1:0] ack_path_status,
  // Outgoing data packet requests from upper clients
  input wire tx_sent,
  input wire tx_ack_req,
  input wire [7:0] tx_max_hops,
  input wire ete_ack_all,
  output reg ete_running,
  output reg [9:0] ete_remaining,
  output reg ete_expired,
  // Payload stream to upper clients through the buffer
  output wire pay_valid,
  input wire pay_ready,
  output wire [7:0] pay_data
);
  reg busy;
  reg [7:0] own_status;
  reg own_is_dest;
  reg own_ack_req;
  reg own_relay;
  reg type_ok;
  reg [31:0] tick_cnt;
  reg [19:0] next_ete;
  integer i;
  integer j;
  wire fifo_in_ready;
  wire take_pay;

  // A new header waits while an ack is pending or the payload buffer is full
  assign rx_ready = !busy && fifo_in_ready;
  assign ack_tx_valid = busy;

  // Only headers that pass every check leave a byte in the buffer
  assign take_pay = rx_valid && rx_ready && type_ok && own_is_dest &&
    rx_header_octet_count >= `IHAE_HEADER_OCTET_COUNT_MIN && rx_version == `IHAE_VERSION;

  // Find this station in the path and read its routing status byte
  always @* begin
    own_status = 8'h00;
    own_is_dest = 1'b0;
    own_ack_req = 1'b0;
    own_relay = 1'b0;
    for (i = 0; i < MAX_PATH; i = i + 1) begin
      if (i < rx_path_len && rx_path_addr[32*i +: 32] == own_addr) begin
        own_status = rx_path_status[8*i +: 8];
      end
    end
    own_is_dest = own_status[`IHAE_STAT_DEST_BIT];
    own_ack_req = own_status[`IHAE_STAT_ACKREQ_BIT];
    own_relay = own_status[`IHAE_STAT_RELAY_BIT];
  end

  // Message type decode
  always @* begin
    case (rx_msg_type)
      `IHAE_MT_ACK, `IHAE_MT_TOPO, `IHAE_MT_TOPO_REQ: type_ok = 1'b1;
      `IHAE_MT_IP, `IHAE_MT_ARP, `IHAE_MT_NPX: type_ok = 1'b1;
      `IHAE_MT_JAH: type_ok = 1'b1;
      `IHAE_MT_SAR: type_ok = 1'b1;
      default: type_ok = 1'b0;
    endcase
  end

  // Receive processing and acknowledgement holding register
  always @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
      deliver_valid <= 1'b0;
      deliver_type <= 4'h0;
      deliver_msg_id <= 8'h00;
      unsupported <= 1'b0;
      header_error <= 1'b0;
      fwd_valid <= 1'b0;
      fwd_hop_limit <= 8'h00;
      ack_version <= `IHAE_VERSION;
      ack_msg_type <= `IHAE_MT_ACK;
      ack_header_octet_count <= `IHAE_HEADER_OCTET_COUNT_MIN;
      ack_msg_id <= 8'h00;
      ack_dest_addr <= 32'h00000000;
      ack_path_len <= 3'h0;
      ack_path_addr <= {(32*MAX_PATH){1'b0}};
      ack_path_status <= {(8*MAX_PATH){1'b0}};
    end else begin
      deliver_valid <= 1'b0;
      unsupported <= 1'b0;
      header_error <= 1'b0;
      fwd_valid <= 1'b0;
      if (busy && ack_tx_ready)
        busy <= 1'b0;
      if (rx_valid && rx_ready) begin
        if (!type_ok) begin
          unsupported <= 1'b1;
        end else if (rx_header_octet_count < `IHAE_HEADER_OCTET_COUNT_MIN ||
                     rx_version != `IHAE_VERSION) begin
          header_error <= 1'b1;
        end else begin
          // local delivery even at hop zero
          if (own_is_dest) begin
            deliver_valid <= 1'b1;
            deliver_type <= rx_msg_type;
            deliver_msg_id <= rx_msg_id;
          end
          if (own_relay && rx_hop_limit > 8'h01) begin
            fwd_valid <= 1'b1;
            fwd_hop_limit <= rx_hop_limit - 8'h01;
          end
          if (own_is_dest && own_ack_req) begin
            busy <= 1'b1;
            ack_version <= `IHAE_VERSION;
            ack_msg_type <= `IHAE_MT_ACK;
            ack_msg_id <= rx_msg_id;
            ack_dest_addr <= rx_orig_addr;
            ack_path_len <= rx_path_len;
            // header octets only, fixed part plus five per hop
            ack_header_octet_count <= `IHAE_HEADER_OCTET_COUNT_MIN + 8'd5 + {rx_path_len, 2'b00} +
              {5'h00, rx_path_len};
            // path reversed, only the last entry is a destination
            for (j = 0; j < MAX_PATH; j = j + 1) begin
              if (j < rx_path_len) begin
                ack_path_addr[32*j +: 32] <= rx_path_addr[32*(rx_path_len-1-j) +: 32];
                ack_path_status[8*j +: 8] <= (j == rx_path_len - 1) ?
                  (8'h01 << `IHAE_STAT_DEST_BIT) : (8'h01 << `IHAE_STAT_RELAY_BIT);
              end else begin
                ack_path_addr[32*j +: 32] <= 32'h00000000;
                ack_path_status[8*j +: 8] <= 8'h00;
              end
            end
          end
        end
      end
    end
  end

  always @* begin
    if (fixed_sec == 10'h000)
      next_ete = {10'h000, `IHAE_FIXED_SEC};
    else
      next_ete = {10'h000, fixed_sec};
    next_ete = next_ete + {9'h000, link_ack_sec, 1'b0} * {12'h000, tx_max_hops}; // No wrap
    if (next_ete > {10'h000, `IHAE_MAX_SEC})
      next_ete = {10'h000, `IHAE_MAX_SEC};
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      tick_cnt <= 32'h00000000;
      ete_running <= 1'b0;
      ete_remaining <= 10'h000;
      ete_expired <= 1'b0;
    end else begin
      ete_expired <= 1'b0;
      if (!ete_running || tick_cnt == TICK_CYCLES - 1)
        tick_cnt <= 32'h00000000;
      else
        tick_cnt <= tick_cnt + 32'h00000001;
      if (tx_sent && tx_ack_req) begin
        ete_running <= 1'b1;
        ete_remaining <= next_ete[9:0];
        tick_cnt <= 32'h00000000;
      end else if (ete_running && ete_ack_all) begin
        ete_running <= 1'b0;
      end else if (ete_running && tick_cnt == TICK_CYCLES - 1) begin
        if (ete_remaining <= 10'h001) begin
          ete_running <= 1'b0;
          ete_remaining <= 10'h000;
          ete_expired <= 1'b1;
        end else begin
          ete_remaining <= ete_remaining - 10'h001;
        end
      end
    end
  end

  // Payload summary byte buffered for delivered packets
  ihae_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(take_pay),
    .in_ready(fifo_in_ready),
    .in_data(rx_payload),
    .out_valid(pay_valid),
    .out_ready(pay_ready),
    .out_data(pay_data)
  );
endmodule // ihae_engine

// File: common/ihae_map.vh
// Constants of the intranet header and acknowledgement engine
`ifndef IHAE_MAP_VH
`define IHAE_MAP_VH
`define IHAE_MT_RSV0 4'h0
`define IHAE_MT_ACK 4'h1
`define IHAE_MT_TOPO 4'h2
`define IHAE_MT_TOPO_REQ 4'h3
`define IHAE_MT_IP 4'h4
`define IHAE_MT_ARP 4'h5
`define IHAE_MT_NPX 4'h6
`define IHAE_MT_JAH 4'h7
`define IHAE_MT_RSV8 4'h8
`define IHAE_MT_RSV9 4'h9
`define IHAE_MT_SAR 4'ha
`define IHAE_VERSION 4'h0
`define IHAE_HEADER_OCTET_COUNT_MIN 8'h03
`define IHAE_STAT_DIST_LSB 0
`define IHAE_STAT_RELAY_BIT 3
`define IHAE_STAT_RTYPE_BIT 4
`define IHAE_STAT_DEST_BIT 5
`define IHAE_STAT_ACKREQ_BIT 6
`define IHAE_FIXED_SEC 10'd20
`define IHAE_MAX_SEC 10'd600
`define IHAE_CLK_HZ 40000000
`define IHAE_TICK_CYCLES (`IHAE_CLK_HZ)
`endif

// File: rtl/ihae_fifo.v
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ihae_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at depth, which need not be a power of two
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // ihae_fifo

// File: verif/ihae_link_model.sv
// Link layer and client stand-in that accepts acks and payload bytes
`timescale 1ns/1ps
module ihae_link_model (
  // Clock and stall control
  input wire ref_clk,
  input wire stall,
  // Ready lines toward the engine
  output logic ack_tx_ready,
  output logic pay_ready
);
  // prompt or slow acceptance
  // Random stalls expose any ack field that moves before acceptance
  always @(negedge ref_clk) begin
    ack_tx_ready <= ($urandom % 3) != 0;
    pay_ready <= !stall && ($urandom % 2);
  end
endmodule // ihae_link_model

// File: verif/ihae_monitor.sv
// Port-level assertions for the engine
`timescale 1ns/1ps
`include "ihae_map.vh"
module ihae_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Receive side
  input wire rx_valid,
  input wire rx_ready,
  input wire [3:0] rx_msg_type,
  input wire [7:0] rx_hop_limit,
  input wire unsupported,
  input wire fwd_valid,
  input wire [7:0] fwd_hop_limit,
  // Ack side
  input wire ack_tx_valid,
  input wire ack_tx_ready,
  input wire [3:0] ack_version,
  input wire [3:0] ack_msg_type,
  input wire [7:0] ack_header_octet_count,
  input wire [7:0] ack_msg_id,
  input wire [2:0] ack_path_len,
  // Timer
  input wire tx_sent,
  input wire tx_ack_req,
  input wire ete_running,
  input wire [9:0] ete_remaining,
  input wire ete_expired
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Accepted header beat
  sequence s_take;
    rx_valid && rx_ready;
  endsequence
  property p_fwd_dec;
    s_take ##1 fwd_valid |-> fwd_hop_limit == $past(rx_hop_limit) - 8'h01;
  endproperty
  a_fwd_dec: assert property (p_fwd_dec) else $error("hop limit not decremented");
  property p_fwd_zero;
    fwd_valid |-> fwd_hop_limit != 8'h00;
  endproperty
  a_fwd_zero: assert property (p_fwd_zero) else $error("forward at zero hops");
  property p_unsup;
    rx_valid && rx_ready && (rx_msg_type == 4'h0 || rx_msg_type == 4'h8 ||
      rx_msg_type == 4'h9) |=> unsupported;
  endproperty
  a_unsup: assert property (p_unsup) else $error("reserved type accepted");
  property p_ack_hdr;
    ack_tx_valid |-> ack_msg_type == `IHAE_MT_ACK && ack_version == `IHAE_VERSION;
  endproperty
  a_ack_hdr: assert property (p_ack_hdr) else $error("ack type or version");
  property p_ack_len;
    ack_tx_valid |-> ack_header_octet_count == 8'h08 + 8'h05 * ack_path_len;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack header length");
  property p_hold;
    ack_tx_valid && !ack_tx_ready |=> ack_tx_valid && $stable(ack_msg_id) && !rx_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("pending ack dropped");
  property p_ack_done;
    ack_tx_valid && ack_tx_ready |=> !ack_tx_valid;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack sent twice");
  property p_ete_start;
    tx_sent && tx_ack_req |=> ete_running && ete_remaining <= 10'd600;
  endproperty
  a_ete_start: assert property (p_ete_start) else $error("timer not started");
  property p_expire;
    ete_expired |-> !ete_running && $past(ete_running);
  endproperty
  a_expire: assert property (p_expire) else $error("stray expiry");
endmodule // ihae_monitor
bind ihae_engine ihae_monitor ihae_monitor_i (.ref_clk(ref_clk), .srst(srst),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_msg_type(rx_msg_type),
  .rx_hop_limit(rx_hop_limit), .unsupported(unsupported), .fwd_valid(fwd_valid),
  .fwd_hop_limit(fwd_hop_limit), .ack_tx_valid(ack_tx_valid), .ack_tx_ready(ack_tx_ready),
  .ack_version(ack_version), .ack_msg_type(ack_msg_type), .ack_msg_id(ack_msg_id),
  .ack_header_octet_count(ack_header_octet_count), .ack_path_len(ack_path_len),
  .tx_sent(tx_sent), .tx_ack_req(tx_ack_req), .ete_running(ete_running),
  .ete_remaining(ete_remaining), .ete_expired(ete_expired));

// File: verif/ihae_engine_tb_top.sv
// Self-checking bench for the intranet header and ack engine
`timescale 1ns/1ps
`include "ihae_map.vh"
module ihae_engine_tb_top;
  logic ref_clk = 0, srst = 1, rx_valid = 0, tx_sent = 0, tx_ack_req = 0, ete_ack_all = 0;
  logic stall = 1, rx_ready, deliver_valid, unsupported, header_error, fwd_valid;
  logic ack_tx_valid, ack_tx_ready, ete_running, ete_expired, pay_valid, pay_ready;
  logic [3:0] rx_version = 0, rx_msg_type = 0, deliver_type, ack_version, ack_msg_type;
  logic [7:0] rx_header_octet_count = 3, rx_msg_id = 0, rx_hop_limit = 0, rx_payload = 0;
  logic [7:0] deliver_msg_id, fwd_hop_limit, ack_header_octet_count, ack_msg_id, pay_data;
  logic [7:0] tx_max_hops = 0;
  logic [31:0] own_addr = 32'h0000_a5c3, rx_orig_addr = 0, ack_dest_addr;
  logic [9:0] fixed_sec = 10'd20, link_ack_sec = 0, ete_remaining;
  logic [2:0] rx_path_len = 1, ack_path_len;
  logic [127:0] rx_path_addr = 0, ack_path_addr;
  logic [31:0] rx_path_status = 0, ack_path_status;
  logic [207:0] exp_del[$], exp_ack[$], exp_pay[$];
  int n_mismatch = 0, total_checks = 0, n_uns = 0, n_herr = 0, n_fwd = 0, i;
  // Free-running clock
  always #12.5 ref_clk = !ref_clk;
  ihae_engine #(.TICK_CYCLES(10)) ihae_engine_i (.*);
  ihae_link_model ihae_link_model_i (.ref_clk(ref_clk), .stall(stall),
    .ack_tx_ready(ack_tx_ready), .pay_ready(pay_ready));
  task automatic chk(input logic [207:0] seen, input logic [207:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One header beat; own entry is the last path entry
  task automatic send(input [3:0] ty, input [3:0] ver, input [7:0] hl, input [7:0] hop,
      input [7:0] st, input [2:0] len);
    int k;
    logic [127:0] rp;
    logic [31:0] rs;
    @(negedge ref_clk);
    {rx_msg_id, rx_orig_addr, rx_payload} = {8'($urandom), $urandom, 8'($urandom)};
    {rx_msg_type, rx_version, rx_header_octet_count, rx_hop_limit, rx_path_len} =
      {ty, ver, hl, hop, len};
    for (k = 0; k < 4; k++) rx_path_addr[32*k+:32] = $urandom;
    rx_path_status = {4{8'h08}};
    rx_path_addr[32*(len-1)+:32] = own_addr;
    rx_path_status[8*(len-1)+:8] = st;
    rx_valid = 1;
    k = 0;
    @(posedge ref_clk);
    while (rx_ready !== 1'b1 && k < 80) begin
      k++;
      @(posedge ref_clk);
    end
    if (rx_ready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    // Ack path is the used entries reversed; only its last entry is a destination
    for (k = 0; k < 4; k++) begin
      rp[32*k+:32] = 32'h0;
      rs[8*k+:8] = 8'h00;
      if (k < len) rp[32*k+:32] = rx_path_addr[32*(len-1-k)+:32];
      if (k < len) rs[8*k+:8] = (k == len - 1) ? 8'h20 : 8'h08;
    end
    if (((ty >= 1 && ty <= 7) || ty == 10) && ver == 0 && hl >= 3 && st[5]) begin
      exp_del.push_back({ty, rx_msg_id});
      exp_pay.push_back(rx_payload);
      if (st[6]) exp_ack.push_back({len, rs, rx_msg_id, rx_orig_addr, rp});
    end
    @(negedge ref_clk);
    rx_valid = 0;
  endtask
  task automatic timer(input [9:0] f, input [9:0] l, input [7:0] h, input [9:0] e);
    @(negedge ref_clk);
    {fixed_sec, link_ack_sec, tx_max_hops, tx_sent, tx_ack_req} = {f, l, h, 2'b11};
    @(negedge ref_clk);
    {tx_sent, tx_ack_req} = 2'b00;
    chk(ete_remaining, e);
  endtask
  // Result watcher compares against the oldest note
  always @(posedge ref_clk) begin
    if (deliver_valid === 1'b1) chk({deliver_type, deliver_msg_id}, exp_del.pop_front());
    if (ack_tx_valid === 1'b1 && ack_tx_ready === 1'b1)
      chk({ack_path_len, ack_path_status, ack_msg_id, ack_dest_addr, ack_path_addr},
        exp_ack.pop_front());
    if (pay_valid === 1'b1 && pay_ready === 1'b1) chk(pay_data, exp_pay.pop_front());
    n_uns += (unsupported === 1'b1);
    n_herr += (header_error === 1'b1);
    n_fwd += (fwd_valid === 1'b1);
  end
  initial begin
    void'($urandom(67642));
    repeat (2) @(negedge ref_clk);
    srst = 0;
    // Every type code while the buffer is stalled
    for (i = 0; i < 16; i++) send(4'((i + 11) % 16), 0, 3, 1, 8'h20, 1);
    repeat (3) @(negedge ref_clk);
    chk(rx_ready, 1'b0);
    chk(n_uns, 8);
    stall = 0;
    $display("test types done");
    send(4, 1, 3, 1, 8'h20, 1);
    send(4, 0, 2, 1, 8'h20, 1);
    @(negedge ref_clk);
    chk(n_herr, 2);
    send(4, 0, 3, 1, 8'h28, 2);
    send(4, 0, 3, 5, 8'h28, 2);
    repeat (2) @(negedge ref_clk);
    chk(n_fwd, 1);
    $display("test hops done");
    for (i = 0; i < 3; i++) send(4, 0, 3, 2, 8'h60, 3'(4 - i));
    $display("test acks done");
    timer(10'd20, 10'd1, 8'd3, 10'd26);
    timer(10'd500, 10'd100, 8'd2, 10'd600);
    timer(10'd2, 10'd1, 8'd3, 10'd8);
    i = 0;
    while (ete_expired !== 1'b1 && i < 200) begin
      i++;
      @(negedge ref_clk);
    end
    chk(i, 80);
    chk(ete_running, 1'b0);
    timer(10'd0, 10'd0, 8'd0, 10'd20);
    ete_ack_all = 1;
    @(negedge ref_clk);
    ete_ack_all = 0;
    @(negedge ref_clk);
    chk(ete_running, 1'b0);
    $display("test timer done");
    i = 0;
    while ((exp_del.size() + exp_ack.size() + exp_pay.size()) > 0 && i < 200) begin
      i++;
      @(negedge ref_clk);
    end
    chk(i < 200, 1'b1);
    tally_and_finish();
  end
endmodule // ihae_engine_tb_top
